// *** verilog/fps_defines.svh ***
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// register offsets (byte addresses, one word each)
`define FPS_OFS_CTRL      8'h00
`define FPS_OFS_RX_ASSIGN 8'h04
`define FPS_OFS_TX_ASSIGN 8'h08
`define FPS_OFS_RX_LEN    8'h0c
`define FPS_OFS_TX_LEN    8'h10
`define FPS_OFS_STATE     8'h14
`define FPS_OFS_STATUS    8'h18
`define FPS_OFS_SDO_FAULT 8'h1c
`define FPS_OFS_ABORT     8'h20
`define FPS_OFS_EMCY      8'h24
`define FPS_OFS_ERR_REG   8'h28
`define FPS_OFS_VEND_ERR  8'h2c

// control and emergency request field positions
`define FPS_CTRL_EMCY_EN  0
`define FPS_CTRL_GEAR_1TO1 1
`define FPS_CTRL_CYC_LSB  4
`define FPS_CTRL_CYC_MSB  6
`define FPS_EMCY_COMM_BIT 8

// reset values
`define FPS_RX_DEFAULT    16'h1701
`define FPS_TX_DEFAULT    16'h1b01
`define FPS_CTRL_RST      32'h0000_0002

// mapping indices
`define FPS_RX_FIX_LO     16'h1701
`define FPS_RX_FIX_HI     16'h1705
`define FPS_RX_VAR        16'h1600
`define FPS_TX_FIX_LO     16'h1b01
`define FPS_TX_FIX_HI     16'h1b04
`define FPS_TX_VAR        16'h1a00
`define FPS_TX_VEND       16'h1bff
`define FPS_MAP_NONE      16'h0000

// limits
`define FPS_RX_MAX_OBJS   8'd10
`define FPS_TX_MAX_OBJS   8'd11
`define FPS_RX_MAX_BYTES  8'd24
`define FPS_TX_MAX_BYTES  8'd30

// emergency frame
`define FPS_EMCY_HI_BYTE  8'hff
`define FPS_EMCY_FUNC_LO  8'h93

// timing: core clock rate and base sync cycle
`define FPS_CLK_MHZ       25
`define FPS_DC_BASE_US    250
`define FPS_DC_BASE_CYC   (`FPS_DC_BASE_US * `FPS_CLK_MHZ)

`endif

// *** verilog/fps_pkg.sv ***
package fps_pkg;
  // fieldbus communication state as written by the stack
  typedef enum logic [1:0] {
    FPS_ST_INIT,
    FPS_ST_PREOP,
    FPS_ST_SAFEOP,
    FPS_ST_OP
  } fps_state_t;

  // service-data fault kinds reported by the mailbox stack
  typedef enum logic [4:0] {
    FPS_F_NONE, FPS_F_TOGGLE, FPS_F_TIMEOUT, FPS_F_CMD, FPS_F_MEM,
    FPS_F_ACCESS, FPS_F_RD_WO, FPS_F_WR_RO, FPS_F_NO_OBJ,
    FPS_F_NOT_MAPPABLE, FPS_F_MAP_LEN, FPS_F_PARAM, FPS_F_INTERNAL,
    FPS_F_HW, FPS_F_LEN, FPS_F_LEN_HI, FPS_F_LEN_LO, FPS_F_NO_SUB,
    FPS_F_RANGE, FPS_F_TOO_HIGH, FPS_F_TOO_LOW, FPS_F_MAX_MIN,
    FPS_F_GENERAL, FPS_F_STORE, FPS_F_LOCAL, FPS_F_DEV_STATE, FPS_F_NO_DICT
  } fps_fault_t;

  typedef enum {
    FPS_E_IDLE,
    FPS_E_SEND
  } fps_emcy_t;
endpackage

// *** verilog/fps_sync_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module fps_sync_gen #(
  parameter int CNT_W = 17
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [CNT_W-1:0] period,
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // free count from the shared clock, one pulse per period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!run || cnt_q >= period - 1'b1) begin
      cnt_q <= '0; // restart aligns the period to the enable edge
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt_q >= period - 1'b1);
    end
  end
endmodule
`default_nettype wire

// *** verilog/fps_slave.sv ***
// Functional notes
// - after reset receive assignment is 1701 and transmit is 1B01
// - receive may combine one of 1701..1705 with the configurable 1600
// - transmit pairs 1B01..1B04 with 1A00 or 1BFF, or 1A00 with 1BFF
// - at most ten objects total in the receive direction
// - at most eleven objects total in the transmit direction
// - too many mapped bytes raises function setting error 93.4
// - too many mapped objects raises function setting error 93.4
// - protocol faults give abort codes 0503 0000 to 0504 0005
// - illegal accesses give abort codes 0601 0000 to 0602 0000
// - unmappable object 0604 0041, mapping too long 0604 0042
// - incompatibility 0604 0043 or 0604 0047, hardware error 0606 0000
// - type or length mismatch 0607 0010, 0607 0012, 0607 0013
// - missing subindex 0609 0011, range codes 0609 0030 to 0609 0036
// - general 0800 0000, store 0800 0020..22, no dictionary 0800 0023
// - distributed-clock sync pulse periodically triggers control processing
// - cycle 250 or 500 us with gear not 1:1 raises error 93.4
// - each error or warning sends an emergency, never a comms error
// - emergency enable flag resets to off, master writes one to enable
// - emergency is 8 bytes: code, error register, vendor bytes
// - emergency error code lies in FF00..FFFF
// - vendor error status object is available to transmit process data
// - assignment changes only accepted in Pre-Operational, not retained
// - subindex 01 objects placed first, 02 second, last duplicate wins
// - transmit mappings together hold at most 30 bytes
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
module fps_slave
  import fps_pkg::*;
#(
  parameter int DC_BASE_CYC = `FPS_DC_BASE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [15:0] rx_map_first,
  output logic [15:0] rx_map_second,
  output logic [15:0] tx_map_first,
  output logic [15:0] tx_map_second,
  output logic [7:0] rx_second_ofs,
  output logic [7:0] tx_second_ofs,
  output logic pd_active,
  output logic func_err,
  output logic ctrl_run,
  output logic [15:0] vendor_err,
  output logic emcy_valid,
  input wire logic emcy_ready,
  output logic [63:0] emcy_data
);
  localparam int CW = 17;

  logic [31:0] ctrl_q;
  logic [31:0] rx_asg_q, tx_asg_q, rx_len_q, tx_len_q;
  fps_state_t state_q;
  logic func_err_q;
  logic [31:0] abort_q;
  logic [7:0] err_reg_q;
  logic [15:0] vend_q;
  fps_emcy_t emcy_st_q;
  logic [63:0] emcy_data_q;
  logic emcy_sw_pend_q, emcy_fn_pend_q;
  logic [7:0] emcy_sw_code_q;
  logic [31:0] rdata_q;
  logic func_err_prev_q;

  logic wr_ctrl, wr_rxa, wr_txa, wr_rxl, wr_txl, wr_state, wr_status;
  logic wr_fault, wr_emcy, wr_errreg, wr_vend;
  logic preop;
  logic rx_ok, tx_ok, cyc_ok, map_ok;
  logic leave_req;
  logic [2:0] cyc_sel;
  logic [CW-1:0] period;
  logic sync_tick;
  logic [8:0] rx_objs, tx_objs, rx_bytes, tx_bytes;
  logic func_set;

  ////////////////////////////////////////////////////////////////////////
  // register decode
  assign wr_ctrl = wr && addr == `FPS_OFS_CTRL;
  assign wr_rxa = wr && addr == `FPS_OFS_RX_ASSIGN;
  assign wr_txa = wr && addr == `FPS_OFS_TX_ASSIGN;
  assign wr_rxl = wr && addr == `FPS_OFS_RX_LEN;
  assign wr_txl = wr && addr == `FPS_OFS_TX_LEN;
  assign wr_state = wr && addr == `FPS_OFS_STATE;
  assign wr_status = wr && addr == `FPS_OFS_STATUS;
  assign wr_fault = wr && addr == `FPS_OFS_SDO_FAULT;
  assign wr_emcy = wr && addr == `FPS_OFS_EMCY;
  assign wr_errreg = wr && addr == `FPS_OFS_ERR_REG;
  assign wr_vend = wr && addr == `FPS_OFS_VEND_ERR;
  assign preop = state_q == FPS_ST_PREOP;

  // control: emergency enable off, gear 1:1, cycle 250 us at reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `FPS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assignments: writes outside pre-op are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_asg_q <= {`FPS_MAP_NONE, `FPS_RX_DEFAULT};
      tx_asg_q <= {`FPS_MAP_NONE, `FPS_TX_DEFAULT};
      rx_len_q <= '0;
      tx_len_q <= '0;
    end else if (preop) begin
      if (wr_rxa) begin
        rx_asg_q <= wdata;
      end
      if (wr_txa) begin
        tx_asg_q <= wdata;
      end
      if (wr_rxl) begin
        rx_len_q <= wdata;
      end
      if (wr_txl) begin
        tx_len_q <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // combination checks
  function automatic logic in_rng(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = v >= lo && v <= hi;
  endfunction

  function automatic logic rx_pair(input logic [15:0] a,
                                   input logic [15:0] b);
    rx_pair = in_rng(a, `FPS_RX_FIX_LO, `FPS_RX_FIX_HI) && b == `FPS_RX_VAR;
  endfunction

  function automatic logic tx_pair(input logic [15:0] a,
                                   input logic [15:0] b);
    tx_pair = (in_rng(a, `FPS_TX_FIX_LO, `FPS_TX_FIX_HI)
               && (b == `FPS_TX_VAR || b == `FPS_TX_VEND))
              || (a == `FPS_TX_VAR && b == `FPS_TX_VEND);
  endfunction

  function automatic logic rx_one(input logic [15:0] a);
    rx_one = in_rng(a, `FPS_RX_FIX_LO, `FPS_RX_FIX_HI) || a == `FPS_RX_VAR;
  endfunction

  function automatic logic tx_one(input logic [15:0] a);
    tx_one = in_rng(a, `FPS_TX_FIX_LO, `FPS_TX_FIX_HI)
             || a == `FPS_TX_VAR || a == `FPS_TX_VEND;
  endfunction

  // either subindex order is a legal pair; order only sets placement
  assign rx_ok = (rx_asg_q[31:16] == `FPS_MAP_NONE) ? rx_one(rx_asg_q[15:0])
               : (rx_pair(rx_asg_q[15:0], rx_asg_q[31:16])
                  || rx_pair(rx_asg_q[31:16], rx_asg_q[15:0]));
  assign tx_ok = (tx_asg_q[31:16] == `FPS_MAP_NONE) ? tx_one(tx_asg_q[15:0])
               : (tx_pair(tx_asg_q[15:0], tx_asg_q[31:16])
                  || tx_pair(tx_asg_q[31:16], tx_asg_q[15:0]));

  // length words: objects first, objects second, bytes first, bytes second
  assign rx_objs = {1'b0, rx_len_q[7:0]} + {1'b0, rx_len_q[15:8]};
  assign tx_objs = {1'b0, tx_len_q[7:0]} + {1'b0, tx_len_q[15:8]};
  assign rx_bytes = {1'b0, rx_len_q[23:16]} + {1'b0, rx_len_q[31:24]};
  assign tx_bytes = {1'b0, tx_len_q[23:16]} + {1'b0, tx_len_q[31:24]};

  assign cyc_sel = ctrl_q[`FPS_CTRL_CYC_MSB:`FPS_CTRL_CYC_LSB];
  // short cycles need a 1:1 gear ratio
  assign cyc_ok = cyc_sel > 3'd4 ? 1'b0
                : (cyc_sel > 3'd1 || ctrl_q[`FPS_CTRL_GEAR_1TO1]);

  assign map_ok = rx_ok && tx_ok
                  && rx_objs <= {1'b0, `FPS_RX_MAX_OBJS}
                  && tx_objs <= {1'b0, `FPS_TX_MAX_OBJS}
                  && rx_bytes <= {1'b0, `FPS_RX_MAX_BYTES}
                  && tx_bytes <= {1'b0, `FPS_TX_MAX_BYTES};

  ////////////////////////////////////////////////////////////////////////
  // state: leaving pre-op is gated by the checks
  assign leave_req = wr_state && preop
                     && wdata[1:0] > 2'(FPS_ST_PREOP);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= FPS_ST_INIT;
    end else if (leave_req && !(map_ok && cyc_ok)) begin
      state_q <= FPS_ST_PREOP;
    end else if (wr_state) begin
      state_q <= fps_state_t'(wdata[1:0]);
    end
  end

  // error 93.4 on a failed check, or a bad cycle while exchanging
  assign func_set = (leave_req && !(map_ok && cyc_ok))
                    || (pd_active && !cyc_ok);

  // sticky; a new failure in the clearing cycle wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      func_err_q <= 1'b0;
    end else if (func_set) begin
      func_err_q <= 1'b1;
    end else if (wr_status && wdata[0]) begin
      func_err_q <= 1'b0;
    end
  end

  assign func_err = func_err_q;
  // no process data while the error stands
  assign pd_active = state_q == FPS_ST_OP && !func_err_q;

  ////////////////////////////////////////////////////////////////////////
  // placement: second mapping begins after the bytes of the first
  assign rx_map_first = rx_asg_q[15:0];
  assign rx_map_second = rx_asg_q[31:16];
  assign tx_map_first = tx_asg_q[15:0];
  assign tx_map_second = tx_asg_q[31:16];
  // duplicates are left to the copier: last write wins
  assign rx_second_ofs = rx_len_q[23:16];
  assign tx_second_ofs = tx_len_q[23:16];

  ////////////////////////////////////////////////////////////////////////
  // sync pulse from the shared clock
  always_comb begin
    case (cyc_sel)
      3'd0: period = CW'(DC_BASE_CYC);
      3'd1: period = CW'(DC_BASE_CYC * 2);
      3'd2: period = CW'(DC_BASE_CYC * 4);
      3'd3: period = CW'(DC_BASE_CYC * 8);
      default: period = CW'(DC_BASE_CYC * 16);
    endcase
  end

  fps_sync_gen #(
    .CNT_W(CW)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .run(state_q != FPS_ST_INIT),
    .period(period),
    .tick(sync_tick)
  );

  // control runs only on a sync pulse with valid process data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_run <= 1'b0;
    end else begin
      ctrl_run <= sync_tick && pd_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // abort code lookup, kept until the next fault report
  function automatic logic [31:0] abort_of(input fps_fault_t f);
    case (f)
      FPS_F_TOGGLE: abort_of = 32'h0503_0000;
      FPS_F_TIMEOUT: abort_of = 32'h0504_0000;
      FPS_F_CMD: abort_of = 32'h0504_0001;
      FPS_F_MEM: abort_of = 32'h0504_0005;
      FPS_F_ACCESS: abort_of = 32'h0601_0000;
      FPS_F_RD_WO: abort_of = 32'h0601_0001;
      FPS_F_WR_RO: abort_of = 32'h0601_0002;
      FPS_F_NO_OBJ: abort_of = 32'h0602_0000;
      FPS_F_NOT_MAPPABLE: abort_of = 32'h0604_0041;
      FPS_F_MAP_LEN: abort_of = 32'h0604_0042;
      FPS_F_PARAM: abort_of = 32'h0604_0043;
      FPS_F_INTERNAL: abort_of = 32'h0604_0047;
      FPS_F_HW: abort_of = 32'h0606_0000;
      FPS_F_LEN: abort_of = 32'h0607_0010;
      FPS_F_LEN_HI: abort_of = 32'h0607_0012;
      FPS_F_LEN_LO: abort_of = 32'h0607_0013;
      FPS_F_NO_SUB: abort_of = 32'h0609_0011;
      FPS_F_RANGE: abort_of = 32'h0609_0030;
      FPS_F_TOO_HIGH: abort_of = 32'h0609_0031;
      FPS_F_TOO_LOW: abort_of = 32'h0609_0032;
      FPS_F_MAX_MIN: abort_of = 32'h0609_0036;
      FPS_F_GENERAL: abort_of = 32'h0800_0000;
      FPS_F_STORE: abort_of = 32'h0800_0020;
      FPS_F_LOCAL: abort_of = 32'h0800_0021;
      FPS_F_DEV_STATE: abort_of = 32'h0800_0022;
      FPS_F_NO_DICT: abort_of = 32'h0800_0023;
      default: abort_of = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      abort_q <= '0;
    end else if (wr_fault) begin
      abort_q <= abort_of(fps_fault_t'(wdata[4:0]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error register and vendor status word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_reg_q <= '0;
      vend_q <= '0;
    end else begin
      if (wr_errreg) begin
        err_reg_q <= wdata[7:0];
      end
      if (wr_vend) begin
        vend_q <= wdata[15:0];
      end
    end
  end

  assign vendor_err = vend_q;

  ////////////////////////////////////////////////////////////////////////
  // emergency requests; comms errors never queue one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      func_err_prev_q <= 1'b0;
    end else begin
      func_err_prev_q <= func_err_q;
    end
  end

  // a request arriving while sending stays pending
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      emcy_sw_pend_q <= 1'b0;
      emcy_sw_code_q <= '0;
    end else if (wr_emcy && !wdata[`FPS_EMCY_COMM_BIT]
                 && ctrl_q[`FPS_CTRL_EMCY_EN]) begin
      emcy_sw_pend_q <= 1'b1;
      emcy_sw_code_q <= wdata[7:0];
    end else if (emcy_st_q == FPS_E_IDLE) begin
      emcy_sw_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      emcy_fn_pend_q <= 1'b0;
    end else if (func_err_q && !func_err_prev_q
                 && ctrl_q[`FPS_CTRL_EMCY_EN]) begin
      emcy_fn_pend_q <= 1'b1;
    end else if (emcy_st_q == FPS_E_IDLE && !emcy_sw_pend_q) begin
      emcy_fn_pend_q <= 1'b0;
    end
  end

  // frame builder: byte 0 in bits 7:0, held until taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      emcy_st_q <= FPS_E_IDLE;
      emcy_data_q <= '0;
    end else begin
      case (emcy_st_q)
        FPS_E_IDLE: begin
          if (emcy_sw_pend_q || emcy_fn_pend_q) begin
            emcy_st_q <= FPS_E_SEND;
            emcy_data_q <= {24'h00_0000, vend_q, err_reg_q,
                            `FPS_EMCY_HI_BYTE,
                            emcy_sw_pend_q ? emcy_sw_code_q
                                           : `FPS_EMCY_FUNC_LO};
          end
        end
        FPS_E_SEND: begin
          if (emcy_ready) begin
            emcy_st_q <= FPS_E_IDLE;
          end
        end
        default: emcy_st_q <= FPS_E_IDLE;
      endcase
    end
  end

  assign emcy_valid = emcy_st_q == FPS_E_SEND;
  assign emcy_data = emcy_data_q;

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (rd) begin
      case (addr)
        `FPS_OFS_CTRL: rdata_q <= ctrl_q;
        `FPS_OFS_RX_ASSIGN: rdata_q <= rx_asg_q;
        `FPS_OFS_TX_ASSIGN: rdata_q <= tx_asg_q;
        `FPS_OFS_RX_LEN: rdata_q <= rx_len_q;
        `FPS_OFS_TX_LEN: rdata_q <= tx_len_q;
        `FPS_OFS_STATE: rdata_q <= {30'h0, state_q};
        `FPS_OFS_STATUS: rdata_q <= {27'h0, emcy_valid, cyc_ok, map_ok,
                                     pd_active, func_err_q};
        `FPS_OFS_ABORT: rdata_q <= abort_q;
        `FPS_OFS_ERR_REG: rdata_q <= {24'h0, err_reg_q};
        `FPS_OFS_VEND_ERR: rdata_q <= {16'h0, vend_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

// *** verif/fps_slave_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fps_slave_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic pd_active,
  input wire logic func_err,
  input wire logic ctrl_run,
  input wire logic emcy_valid,
  input wire logic emcy_ready,
  input wire logic [63:0] emcy_data
);
  logic en_q;

  // enable bit as last written
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (wr && addr == 8'h00) begin
      en_q <= wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single clock domain
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero");
  emcy_hold_a: assert property (
    emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_data))
    else $error("emergency frame not held");
  emcy_code_a: assert property (
    emcy_valid |-> emcy_data[15:8] == 8'hff)
    else $error("emergency code outside vendor range");
  emcy_tail_a: assert property (
    emcy_valid |-> emcy_data[63:40] == 24'h0)
    else $error("emergency reserved bytes not zero");
  emcy_gate_a: assert property ($rose(emcy_valid) |-> en_q)
    else $error("emergency offered while disabled");
  run_space_a: assert property (ctrl_run |=> !ctrl_run [*8])
    else $error("control pulses too close");
  run_gate_a: assert property (ctrl_run |-> $past(pd_active))
    else $error("control pulse without process data");
  err_block_a: assert property (func_err |=> !ctrl_run)
    else $error("control pulse during function error");
  pd_cause_a: assert property ($rose(pd_active) |->
    $past(wr) && ($past(addr) == 8'h14 || $past(addr) == 8'h18))
    else $error("process data start without write");
endmodule
bind fps_slave fps_slave_chk chk (
  .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .pd_active(pd_active), .func_err(func_err),
  .ctrl_run(ctrl_run), .emcy_valid(emcy_valid), .emcy_ready(emcy_ready),
  .emcy_data(emcy_data)
);
`default_nettype wire

// *** verif/fps_mbx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fps_mbx_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic emcy_valid,
  input wire logic [63:0] emcy_data,
  output logic emcy_ready,
  output logic [63:0] frame,
  output logic [7:0] n_frames
);
  logic [3:0] wait_q;

  // slow mode stalls ready to stress the hold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      emcy_ready <= 1'b0;
      frame <= 64'h0;
      n_frames <= 8'h0;
      wait_q <= 4'h0;
    end else if (emcy_valid && emcy_ready) begin
      emcy_ready <= 1'b0;
      frame <= emcy_data;
      n_frames <= n_frames + 8'h1;
      wait_q <= 4'h0;
    end else if (emcy_valid) begin
      if (wait_q >= (slow ? 4'h5 : 4'h0)) begin
        emcy_ready <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/fieldbus_slave_pdo_sdo_sync_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
module fieldbus_slave_pdo_sdo_sync_test;
  typedef struct packed {
    logic [31:0] ra, rl, ta, tl;
    logic ok;
  } fps_case_t;
  logic core_clk, rst, wr, rd, slow, pd_active, func_err, ctrl_run;
  logic emcy_valid, emcy_ready;
  logic [7:0] addr, rx_second_ofs, tx_second_ofs, n_frames;
  logic [31:0] wdata, rdata;
  logic [15:0] rx_map_first, rx_map_second, tx_map_first, tx_map_second;
  logic [15:0] vendor_err;
  logic [63:0] emcy_data, frame;
  int n_mismatch = 0, compares = 0, n;
  localparam logic [31:0] abort_codes [26] = '{
    32'h05030000, 32'h05040000, 32'h05040001, 32'h05040005, 32'h06010000,
    32'h06010001, 32'h06010002, 32'h06020000, 32'h06040041, 32'h06040042,
    32'h06040043, 32'h06040047, 32'h06060000, 32'h06070010, 32'h06070012,
    32'h06070013, 32'h06090011, 32'h06090030, 32'h06090031, 32'h06090032,
    32'h06090036, 32'h08000000, 32'h08000020, 32'h08000021, 32'h08000022,
    32'h08000023};
  // boundary totals, one object or byte limit broken per case, then illegal and legal pairings
  localparam fps_case_t cases [10] = '{
    '{32'h16001705, 32'h0c0c0505, 32'h1a001b04, 32'h0f0f0506, 1'b1},
    '{32'h16001705, 32'h0c0c0506, 32'h00001b01, 32'h000a0004, 1'b0},
    '{32'h00001701, 32'h00060003, 32'h1a001b04, 32'h0f0f0606, 1'b0},
    '{32'h00001701, 32'h00060003, 32'h1a001b04, 32'h0f100506, 1'b0},
    '{32'h16001705, 32'h0c0d0505, 32'h00001b01, 32'h000a0004, 1'b0},
    '{32'h17021701, 32'h00060003, 32'h00001b01, 32'h000a0004, 1'b0},
    '{32'h00001701, 32'h00060003, 32'h1b021b01, 32'h000a0004, 1'b0},
    '{32'h00001701, 32'h00060003, 32'h1bff1a00, 32'h01010301, 1'b1},
    '{32'h00001701, 32'h00060003, 32'h1bff1b02, 32'h01010301, 1'b1},
    '{32'h16001706, 32'h00060003, 32'h00001b01, 32'h000a0004, 1'b0}};

  fps_slave #(.DC_BASE_CYC(16)) uut (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_map_first(rx_map_first),
    .rx_map_second(rx_map_second), .tx_map_first(tx_map_first),
    .tx_map_second(tx_map_second), .rx_second_ofs(rx_second_ofs),
    .tx_second_ofs(tx_second_ofs), .pd_active(pd_active),
    .func_err(func_err), .ctrl_run(ctrl_run), .vendor_err(vendor_err),
    .emcy_valid(emcy_valid), .emcy_ready(emcy_ready), .emcy_data(emcy_data)
  );
  fps_mbx_model mbx (
    .core_clk(core_clk), .rst(rst), .slow(slow), .emcy_valid(emcy_valid),
    .emcy_data(emcy_data), .emcy_ready(emcy_ready), .frame(frame),
    .n_frames(n_frames)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #20 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobes launched just after an edge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  task automatic apply(input fps_case_t c);
    wreg(`FPS_OFS_STATE, 32'h1);
    wreg(`FPS_OFS_STATUS, 32'h1);
    wreg(`FPS_OFS_RX_ASSIGN, c.ra);
    wreg(`FPS_OFS_TX_ASSIGN, c.ta);
    wreg(`FPS_OFS_RX_LEN, c.rl);
    wreg(`FPS_OFS_TX_LEN, c.tl);
    wreg(`FPS_OFS_STATE, 32'h3);
    settle(2);
  endtask

  // cycles between two control pulses
  task automatic period(output int c);
    c = 0;
    while (ctrl_run !== 1'b1 && c < 600) begin
      settle(1);
      c++;
    end
    c = 0;
    do begin
      settle(1);
      c++;
    end while (ctrl_run !== 1'b1 && c < 600);
  endtask

  task automatic wait_frames(input logic [7:0] k);
    for (int i = 0; i < 60 && n_frames !== k; i++) begin
      @(posedge core_clk);
    end
    #1;
    chk("frames", n_frames, k);
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog far past the few thousand cycles needed
  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    settle(1);
    chk("rx_first", rx_map_first, `FPS_RX_DEFAULT);
    chk("tx_first", tx_map_first, `FPS_TX_DEFAULT);
    rchk(`FPS_OFS_CTRL, `FPS_CTRL_RST, "ctrl");
    rchk(8'h30, 32'h0, "unmapped");
    rchk(`FPS_OFS_SDO_FAULT, 32'h0, "write_only");
    wreg(`FPS_OFS_RX_ASSIGN, 32'h16001702);
    rchk(`FPS_OFS_RX_ASSIGN, 32'h00001701, "assign_init");
    $display("test reset done");
    for (int k = 1; k <= 26; k++) begin
      wreg(`FPS_OFS_SDO_FAULT, 32'(k));
      rchk(`FPS_OFS_ABORT, abort_codes[k-1], "abort");
    end
    $display("test abort done");
    for (int i = 0; i < 10; i++) begin
      apply(cases[i]);
      chk("pd_active", pd_active, cases[i].ok);
      chk("func_err", func_err, !cases[i].ok);
      if (cases[i].ok) begin
        chk("rx_first", rx_map_first, cases[i].ra[15:0]);
        chk("rx_second", rx_map_second, cases[i].ra[31:16]);
        chk("tx_second", tx_map_second, cases[i].ta[31:16]);
        chk("rx_ofs", rx_second_ofs, cases[i].rl[23:16]);
        chk("tx_ofs", tx_second_ofs, cases[i].tl[23:16]);
      end else begin
        rchk(`FPS_OFS_STATE, 32'h1, "state");
      end
    end
    $display("test mapping done");
    apply(cases[0]);
    for (int s = 0; s < 5; s++) begin
      wreg(`FPS_OFS_CTRL, 32'h2 | (s << 4));
      period(n);
      period(n);
      chk("period", n, 16 << s);
    end
    wreg(`FPS_OFS_CTRL, 32'h20);
    settle(3);
    chk("err_1ms", func_err, 1'b0);
    wreg(`FPS_OFS_CTRL, 32'h10);
    settle(3);
    chk("err_500us", func_err, 1'b1);
    chk("pd_off", pd_active, 1'b0);
    chk("no_frame", n_frames, 8'h0);
    $display("test sync done");
    wreg(`FPS_OFS_STATE, 32'h1);
    wreg(`FPS_OFS_STATUS, 32'h1);
    wreg(`FPS_OFS_CTRL, 32'h23);
    wreg(`FPS_OFS_ERR_REG, 32'h5a);
    wreg(`FPS_OFS_VEND_ERR, 32'hbeef);
    chk("vendor", vendor_err, 16'hbeef);
    wreg(`FPS_OFS_EMCY, 32'h12);
    wait_frames(8'h1);
    chk("frame", frame, 64'h000000_beef_5a_ff12);
    wreg(`FPS_OFS_EMCY, 32'h134);
    settle(8);
    chk("comms", n_frames, 8'h1);
    slow <= 1'b1;
    wreg(`FPS_OFS_EMCY, 32'h77);
    wait_frames(8'h2);
    chk("slow_code", frame[15:0], 16'hff77);
    wreg(`FPS_OFS_CTRL, 32'h01);
    wreg(`FPS_OFS_STATE, 32'h3);
    wait_frames(8'h3);
    chk("err_code", frame[15:0], {8'hff, `FPS_EMCY_FUNC_LO});
    wreg(`FPS_OFS_STATUS, 32'h1);
    wreg(`FPS_OFS_CTRL, 32'h02);
    wreg(`FPS_OFS_EMCY, 32'h55);
    settle(8);
    chk("disabled", n_frames, 8'h3);
    $display("test emergency done");
    close_out();
  end
endmodule
`default_nettype wire
